// ==== uart_rx_pkg.sv ====
package uart_rx_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] ADDR_STATUS_A  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B = 4'h4;
  localparam logic [3:0] ADDR_CONTROL_C = 4'h8;
  localparam logic [3:0] ADDR_DATA      = 4'hC;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STA_RXC      = 7;
  localparam int STA_FE       = 4;
  localparam int STA_DOR      = 3;
  localparam int STA_UPE      = 2;
  localparam int CTB_RXCIE    = 7;
  localparam int CTB_RXEN     = 4;
  localparam int CTB_RX9      = 1;
  localparam int CTB_TX9      = 0;
  localparam int CTC_PAR_EN   = 5;
  localparam int CTC_PAR_ODD  = 4;
  localparam int CTC_STOP2    = 3;
  localparam int CTC_SIZE_LSB = 0;

  // ****************************************
  // Reset values, encodings, timing
  // ****************************************
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [7:0] CONTROL_C_RESET = 8'h03;
  localparam logic [7:0] RX9_CLEAR_MASK  = 8'hFD;
  localparam logic [2:0] CHAR_SIZE_9     = 3'h7;
  localparam logic [3:0] NINE_BITS       = 4'h9;
  localparam logic [3:0] MIN_BITS        = 4'h5;
  localparam int         BIT_CYCLES_DEF  = 16;
  localparam logic [1:0] FIFO_FULL       = 2'h2;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       fe;
    logic       dor;
    logic       upe;
  } rx_frame_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;

endpackage : uart_rx_pkg

// ==== uart_rx_buffer.sv ====
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module uart_rx_buffer
  import uart_rx_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
  // Clock, reset, enable
  input  logic        clk,
  input  logic        nrst,
  input  logic        ce,
  // Avalon-MM slave
  input  logic [3:0]  address,
  input  logic        read,
  input  logic        write,
  input  logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic        waitrequest,
  // Serial line and core
  input  logic        serial_rx_pin,
  input  logic        global_irq_en,
  output logic        rx_irq,
  output logic        rx_pin_override
);

  localparam logic [15:0] BIT_CNT  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_CNT = 16'(BIT_CYCLES / 2 - 1);

  typedef struct packed {
    rx_frame_t [1:0] fifo;
    logic            rptr;
    logic [1:0]      count;
    rx_frame_t       hold;
    logic            hold_valid;
    logic            ovr_pend;
    rx_state_t       st;
    logic [15:0]     cnt;
    logic [3:0]      idx;
    logic [8:0]      sh;
    logic            par_bit;
    logic            pin_q;
    logic [7:0]      ctl_b;
    logic [7:0]      ctl_c;
    logic            waitreq;
    logic [31:0]     rdata;
    logic            pop_ok;
    logic            irq;
    logic            pin_ovr;
  } state_t;

  state_t     r_reg;
  state_t     r_next;
  logic [3:0] nbits;
  logic       par_en;
  logic       accept;
  logic       pop;
  logic [1:0] left;
  logic       have;
  rx_frame_t  head;
  logic [31:0] rd_mux;

  function automatic logic [3:0] data_bits(input logic [2:0] size);
    data_bits = (size == CHAR_SIZE_9) ? NINE_BITS : MIN_BITS + {2'b00, size[1:0]};
  endfunction : data_bits

  // ****************************************
  // Read data selection
  // ****************************************
  always_comb begin
    have   = r_reg.count != 2'h0;
    head   = r_reg.fifo[r_reg.rptr];
    rd_mux = 32'h0000_0000;
    case (address)
      ADDR_STATUS_A: begin
        rd_mux[STA_RXC] = have;
        rd_mux[STA_FE]  = have & head.fe;
        rd_mux[STA_DOR] = have & head.dor;
        rd_mux[STA_UPE] = have & head.upe & r_reg.ctl_c[CTC_PAR_EN];
      end
      ADDR_CONTROL_B: begin
        rd_mux[7:0]     = r_reg.ctl_b;
        rd_mux[CTB_RX9] = have & head.ninth;
      end
      ADDR_CONTROL_C: rd_mux[7:0] = r_reg.ctl_c;
      ADDR_DATA:      rd_mux[7:0] = have ? head.data : 8'h00;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    nbits  = data_bits(r_reg.ctl_c[CTC_SIZE_LSB +: 3]);
    par_en = r_reg.ctl_c[CTC_PAR_EN];
    accept = (read || write) && !r_reg.waitreq;

    // One wait cycle; read data is frozen before the accepting edge
    r_next.waitreq = 1'b1;
    if ((read || write) && r_reg.waitreq) begin
      r_next.waitreq = 1'b0;
      r_next.rdata   = rd_mux;
      r_next.pop_ok  = read && (address == ADDR_DATA) && have;
    end
    pop = accept && read && (address == ADDR_DATA) && r_reg.pop_ok;

    if (accept && write) begin
      case (address)
        ADDR_CONTROL_B: r_next.ctl_b = writedata[7:0] & RX9_CLEAR_MASK;
        ADDR_CONTROL_C: r_next.ctl_c = writedata[7:0];
        default: ;
      endcase
    end

    r_next.pin_q = serial_rx_pin;
    case (r_reg.st)
      RX_IDLE: begin
        if (r_reg.ctl_b[CTB_RXEN] && r_reg.pin_q && !serial_rx_pin) begin
          r_next.st  = RX_START;
          r_next.cnt = HALF_CNT;
        end
      end
      RX_START: begin
        if (r_reg.cnt != 16'h0000) begin
          r_next.cnt = r_reg.cnt - 16'h0001;
        end else if (serial_rx_pin) begin
          r_next.st = RX_IDLE;
        end else begin
          r_next.st  = RX_BITS;
          r_next.cnt = BIT_CNT;
          r_next.idx = 4'h0;
          r_next.sh  = 9'h000;
          if (r_reg.hold_valid && r_reg.count == FIFO_FULL && !pop) begin
            r_next.ovr_pend   = 1'b1;
            r_next.hold_valid = 1'b0;
          end
        end
      end
      RX_BITS: begin
        if (r_reg.cnt != 16'h0000) begin
          r_next.cnt = r_reg.cnt - 16'h0001;
        end else begin
          r_next.cnt = BIT_CNT;
          if (r_reg.idx < nbits) begin
            r_next.sh[r_reg.idx] = serial_rx_pin;
          end else begin
            r_next.par_bit = serial_rx_pin;
          end
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx == 4'(nbits + {3'b000, par_en} - 4'h1)) begin
            r_next.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (r_reg.cnt != 16'h0000) begin
          r_next.cnt = r_reg.cnt - 16'h0001;
        end else begin
          r_next.st          = RX_IDLE;
          r_next.hold.ninth  = r_reg.sh[8];
          r_next.hold.data   = r_reg.sh[7:0];
          r_next.hold.fe     = !serial_rx_pin;
          r_next.hold.dor    = 1'b0;
          r_next.hold.upe    = par_en &
                               (^r_reg.sh ^ r_reg.ctl_c[CTC_PAR_ODD] ^ r_reg.par_bit);
          r_next.hold_valid  = 1'b1;
        end
      end
      default: r_next.st = RX_IDLE;
    endcase

    left         = r_reg.count - {1'b0, pop};
    r_next.rptr  = r_reg.rptr ^ pop;
    r_next.count = left;
    if (r_next.hold_valid && left != FIFO_FULL) begin
      r_next.fifo[r_next.rptr ^ left[0]]     = r_next.hold;
      r_next.fifo[r_next.rptr ^ left[0]].dor = r_next.ovr_pend;
      r_next.hold_valid = 1'b0;
      r_next.ovr_pend   = 1'b0;
      r_next.count      = left + 2'h1;
    end

    if (!r_next.ctl_b[CTB_RXEN]) begin
      r_next.count      = 2'h0;
      r_next.hold_valid = 1'b0;
      r_next.ovr_pend   = 1'b0;
      r_next.st         = RX_IDLE;
    end
    r_next.irq     = (r_next.count != 2'h0) && r_next.ctl_b[CTB_RXCIE] && global_irq_en;
    r_next.pin_ovr = r_next.ctl_b[CTB_RXEN];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg         <= '0;
      r_reg.ctl_b   <= CONTROL_B_RESET;
      r_reg.ctl_c   <= CONTROL_C_RESET;
      r_reg.waitreq <= 1'b1;
      r_reg.pin_q   <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign readdata        = r_reg.rdata;
  assign waitrequest     = r_reg.waitreq;
  assign rx_irq          = r_reg.irq;
  assign rx_pin_override = r_reg.pin_ovr;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  bus_answer_a: assert property ( // bus handshake
    ce && (read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest did not drop one cycle after request");

  irq_has_data_a: assert property (
    rx_irq |-> r_reg.count != 2'h0)
    else $error("interrupt raised with empty buffer");

  irq_level_a: assert property (
    ce && r_next.count != 2'h0 && r_next.ctl_b[CTB_RXCIE] && global_irq_en |=> rx_irq)
    else $error("interrupt not held while data pending");

  disable_flush_a: assert property (
    ce && accept && write && address == ADDR_CONTROL_B && !writedata[CTB_RXEN]
    |=> r_reg.count == 2'h0 && r_reg.st == RX_IDLE && !rx_pin_override)
    else $error("receiver disable did not flush");

  read_pop_a: assert property (
    ce && pop && !r_reg.hold_valid && !(r_reg.st == RX_STOP && r_reg.cnt == 16'h0000) &&
    r_reg.ctl_b[CTB_RXEN] && !write
    |=> r_reg.count == $past(r_reg.count) - 2'h1)
    else $error("data read did not advance buffer");

  stop_check_a: assert property (
    ce && r_reg.st == RX_STOP && r_reg.cnt == 16'h0000 && r_next.ctl_b[CTB_RXEN]
    |=> r_reg.hold.fe == !$past(serial_rx_pin))
    else $error("frame error does not follow stop bit");

  overrun_set_a: assert property (
    ce && r_reg.st == RX_START && r_reg.cnt == 16'h0000 && !serial_rx_pin &&
    r_reg.hold_valid && r_reg.count == FIFO_FULL && !pop && r_next.ctl_b[CTB_RXEN]
    |=> r_reg.ovr_pend)
    else $error("overrun not flagged");

  overrun_clear_a: assert property (
    ce && r_reg.hold_valid && left != FIFO_FULL |=> !r_reg.ovr_pend && !r_reg.hold_valid)
    else $error("overrun not cleared on move");

  parity_off_a: assert property (
    ce && accept && read && address == ADDR_STATUS_A && !r_reg.ctl_c[CTC_PAR_EN]
    |-> !readdata[STA_UPE])
    else $error("parity error visible while checking off");

  frame_stored_c: cover property (r_reg.hold_valid ##1 r_reg.count != 2'h0);
  overrun_c: cover property (r_reg.ovr_pend ##[1:300] !r_reg.ovr_pend);
  irq_c: cover property (rx_irq ##[1:50] !rx_irq);
  fifo_full_c: cover property (r_reg.count == FIFO_FULL && r_reg.hold_valid);

endmodule : uart_rx_buffer

// ==== uart_serial_tx_model.sv ====
`timescale 1ns/1ps

// ****************************************
// Remote serial transmitter
// ****************************************
module uart_serial_tx_model #(
  parameter int BIT_CYCLES = 16
) (
  // Clock
  input  wire logic clk,
  // Serial line, idle high
  output logic      line
);
  initial line = 1'b1;

  task automatic put_bit(input logic b);
    line <= b;
    repeat (BIT_CYCLES) @(posedge clk);
  endtask : put_bit

  task automatic send(input logic [8:0] d, input int nb, input logic pe,
                      input logic pb, input logic stop);
    @(posedge clk);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++) begin
      put_bit(d[i]);
    end
    if (pe) begin
      put_bit(pb);
    end
    put_bit(stop);
    // Back to idle so a zero stop bit cannot hide the falling edge of the next start
    line <= 1'b1;
  endtask : send
endmodule : uart_serial_tx_model

// ==== uart_receive_buffer_status_bench.sv ====
`timescale 1ns/1ps

module uart_receive_buffer_status_bench;
  import uart_rx_pkg::*;

  localparam int BC = 8;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rx_line;
  logic        global_irq_en = 1'b0;
  logic        rx_irq;
  logic        rx_pin_override;
  int          errors = 0;
  int          tests_run = 0;
  int          seed = 32'h0000_ad79;
  rx_frame_t   exp_q[$];
  logic [31:0] rd;
  logic [7:0]  ctb = 8'h90;
  logic [7:0]  cfg;

  always #5 clk = ~clk;

  uart_rx_buffer #(.BIT_CYCLES(BC)) dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .serial_rx_pin(rx_line),
    .global_irq_en(global_irq_en), .rx_irq(rx_irq), .rx_pin_override(rx_pin_override));

  uart_serial_tx_model #(.BIT_CYCLES(BC)) tx (.clk(clk), .line(rx_line));

  task automatic stop_test;
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      errors++;
      stop_test();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic send_frame(input logic [7:0] c, input logic bad_par, input logic bad_stop);
    rx_frame_t f;
    int nb;
    logic [8:0] d;
    nb = (c[2:0] == CHAR_SIZE_9) ? 9 : 5 + c[1:0];
    d = 9'($random(seed)) & ((9'h1 << nb) - 9'h1);
    f = '{ninth: d[8], data: d[7:0], fe: bad_stop, dor: 1'b0, upe: c[5] & bad_par};
    tx.send(d, nb, c[5], (^d) ^ c[4] ^ bad_par, !bad_stop);
    exp_q.push_back(f);
  endtask : send_frame

  // ****************************************
  // Software read sequence: status, ninth bit, then data
  // ****************************************
  task automatic drain;
    rx_frame_t f;
    while (exp_q.size() > 0) begin
      f = exp_q.pop_front();
      bus(1'b1, ADDR_STATUS_A, 8'h00);
      bus(1'b0, ADDR_STATUS_A, 8'h00);
      chk(rd, {24'h00_0000, 3'b100, f.fe, f.dor, f.upe, 2'b00});
      bus(1'b0, ADDR_CONTROL_B, 8'h00);
      chk(rd, {24'h00_0000, ctb[7:2], f.ninth, ctb[0]});
      bus(1'b0, ADDR_DATA, 8'h00);
      chk(rd, {24'h00_0000, f.data});
    end
    bus(1'b0, ADDR_STATUS_A, 8'h00);
    chk(rd, 32'h0000_0000);
    chk(rx_irq, 1'b0);
  endtask : drain

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, ADDR_CONTROL_C, 8'h00);
    chk(rd, {24'h00_0000, CONTROL_C_RESET});
    bus(1'b0, 4'h2, 8'h00);
    chk(rd, 32'h0000_0000);
    bus(1'b1, ADDR_CONTROL_B, ctb);
    chk(rx_pin_override, 1'b1);
    for (int i = 0; i < 15; i++) begin
      cfg = {2'b00, 3'($random(seed)), (i % 5 == 4) ? CHAR_SIZE_9 : 3'(i % 5)};
      global_irq_en <= i[0];
      bus(1'b1, ADDR_CONTROL_C, cfg);
      bus(1'b0, ADDR_CONTROL_C, 8'h00);
      chk(rd, {24'h00_0000, cfg});
      send_frame(cfg, 1'($random(seed)), 1'($random(seed)));
      chk(rx_irq, i[0]);
      drain();
    end
    // Overrun: two buffered, one waiting, fourth start loses the third
    bus(1'b1, ADDR_CONTROL_C, 8'h33);
    repeat (4) send_frame(8'h33, 1'b0, 1'b0);
    exp_q.delete(2);
    exp_q[2].dor = 1'b1;
    drain();
    send_frame(8'h33, 1'b1, 1'b0);
    drain();
    // flush by reading data until receive-complete clears
    repeat (2) send_frame(8'h33, 1'b0, 1'b0);
    exp_q.delete();
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, ADDR_STATUS_A, 8'h00);
      if (rd[STA_RXC]) bus(1'b0, ADDR_DATA, 8'h00);
    end
    chk(rd, 32'h0000_0000);
    // Disable flushes the buffer and releases the pin
    repeat (2) send_frame(8'h33, 1'b0, 1'b0);
    ctb = 8'h80;
    bus(1'b1, ADDR_CONTROL_B, ctb);
    chk(rx_pin_override, 1'b0);
    bus(1'b0, ADDR_STATUS_A, 8'h00);
    chk(rd, 32'h0000_0000);
    exp_q.delete();
    // Mid-run reset puts the receiver back to its idle defaults
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, ADDR_CONTROL_B, 8'h00);
    chk(rd, {24'h00_0000, CONTROL_B_RESET});
    chk(rx_pin_override, 1'b0);
    ctb = 8'h90;
    bus(1'b1, ADDR_CONTROL_B, ctb);
    bus(1'b1, ADDR_CONTROL_C, 8'h33);
    send_frame(8'h33, 1'b0, 1'b1);
    drain();
    stop_test();
  end
endmodule : uart_receive_buffer_status_bench
